// file: core/imdc_consts.svh
// register offsets, field positions, reset values and decode codes for the mir/dma config bank
`ifndef IMDC_CONSTS_SVH
`define IMDC_CONSTS_SVH

`define IMDC_MIR_OFS      32'h0C00_0060
`define IMDC_DMA_OFS      32'h0C00_0062

`define IMDC_FLAG_MSB     7
`define IMDC_FLAG_LSB     5
`define IMDC_WIDTH_MSB    4
`define IMDC_ACC_BIT      7
`define IMDC_DIR_BIT      6
`define IMDC_DEM_MSB      2

`define IMDC_MIR_RST      8'h49
`define IMDC_DIR_RST      1'h0
`define IMDC_DEM_RST      3'h0

`define IMDC_FLAG_C1      3'h1
`define IMDC_FLAG_C2      3'h2
`define IMDC_FLAG_C4      3'h3
`define IMDC_FLAG_C16     3'h4
`define IMDC_FLAG_C32     3'h7
`define IMDC_DEM_FREE     3'h7

`endif

// file: core/imdc_pkg.sv
// types shared by the mir/dma configuration bank
package imdc_pkg;

  typedef enum logic {
    IMDC_IDLE,
    IMDC_ACTIVE
  } imdc_frame_t;

  typedef logic [5:0] imdc_count_t;

endpackage

// file: core/imdc_regs.sv
// mir transmit and dma setup register bank with per-frame setting latch and pulse timer
`timescale 1ns/1ps
`include "imdc_consts.svh"

// Overview of operation
// - the opening-flag count code maps 001/010/011/100/111 to 1/2/4/16/32 flags and every other code to 2.
// - each output pulse lasts the five-bit width value plus one clocks, from 1 up to 32.
// - the pulse is meant to be about a quarter bit period, so the width chosen sets that fraction.
// - the direction bit at 0 moves memory into the transmit data reg, at 1 the receive data reg into memory.
// - demand codes 000 to 110 give sizes one to seven and code 111 gives free size.
// - the access mode select bit is written as zero and always reads back as zero.
// - reserved bits, the upper byte among them, are written as zero and always read as zero.
module imdc_regs
  import imdc_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  input  wire logic [31:0] I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic        I_FRAME_START,
  input  wire logic        I_FRAME_DONE,
  input  wire logic        I_PULSE_REQ,
  output logic      [15:0] O_RDATA,
  output logic      [5:0]  O_FLAG_COUNT,
  output logic      [5:0]  O_PULSE_CLKS,
  output logic             O_FRAME_ACTIVE,
  output logic             O_IR_PULSE,
  output logic             O_TO_TX,
  output logic             O_FROM_RX,
  output logic      [2:0]  O_DEMAND_SIZE,
  output logic             O_DEMAND_FREE
);

  logic        [7:0]  mir;
  logic        [7:0]  next_mir;
  logic               dir;
  logic               next_dir;
  logic        [2:0]  dem;
  logic        [2:0]  next_dem;
  logic        [15:0] next_rdata;
  logic               hit_mir;
  logic               hit_dma;
  imdc_frame_t        state;
  imdc_frame_t        next_state;
  imdc_count_t        next_flag;
  imdc_count_t        next_width;
  imdc_count_t        pulse_cnt;
  imdc_count_t        next_pulse_cnt;
  logic               next_pulse;
  logic               next_to_tx;
  logic               next_from_rx;
  logic        [2:0]  next_size;
  logic               next_free;
  logic               next_active;

  function automatic imdc_count_t flag_decode(input logic [2:0] code);
    case (code)
      `IMDC_FLAG_C1:  flag_decode = 6'h01;
      `IMDC_FLAG_C2:  flag_decode = 6'h02;
      `IMDC_FLAG_C4:  flag_decode = 6'h04;
      `IMDC_FLAG_C16: flag_decode = 6'h10;
      `IMDC_FLAG_C32: flag_decode = 6'h20;
      default:        flag_decode = 6'h02;
    endcase
  endfunction

  // full address compare: nothing outside the two offsets aliases onto them
  assign hit_mir = (I_ADDR == `IMDC_MIR_OFS);
  assign hit_dma = (I_ADDR == `IMDC_DMA_OFS);

  // register file: writes, and read data for the following cycle only
  always_comb begin
    next_mir   = mir;
    next_dir   = dir;
    next_dem   = dem;
    next_rdata = 16'h0000;
    if (I_WR && hit_mir) begin
      next_mir = I_WDATA[7:0];
    end else if (I_WR && hit_dma) begin
      // access mode select has no storage, so it can never read back as one
      next_dir = I_WDATA[`IMDC_DIR_BIT];
      next_dem = I_WDATA[`IMDC_DEM_MSB:0];
    end
    if (I_RD && hit_mir) begin
      next_rdata = {8'h00, mir};
    end else if (I_RD && hit_dma) begin
      next_rdata = {8'h00, 1'b0, dir, 3'h0, dem};
    end
  end

  // dma steering decoded straight from the next stored values
  // free size has no fixed length, so the size output shows zero then
  always_comb begin
    next_to_tx   = ~next_dir;
    next_from_rx = next_dir;
    next_free    = (next_dem == `IMDC_DEM_FREE);
    next_size    = next_free ? 3'h0 : 3'(next_dem + 3'h1);
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mir           <= `IMDC_MIR_RST;
      dir           <= `IMDC_DIR_RST;
      dem           <= `IMDC_DEM_RST;
      O_RDATA       <= 16'h0000;
      O_TO_TX       <= 1'h1;
      O_FROM_RX     <= 1'h0;
      O_DEMAND_SIZE <= 3'h1;
      O_DEMAND_FREE <= 1'h0;
    end else begin
      mir           <= next_mir;
      dir           <= next_dir;
      dem           <= next_dem;
      O_RDATA       <= next_rdata;
      O_TO_TX       <= next_to_tx;
      O_FROM_RX     <= next_from_rx;
      O_DEMAND_SIZE <= next_size;
      O_DEMAND_FREE <= next_free;
    end
  end

  // frame latch: a write during a frame cannot disturb the frame already in flight
  always_comb begin
    next_state = state;
    next_flag  = O_FLAG_COUNT;
    next_width = O_PULSE_CLKS;
    case (state)
      IMDC_IDLE: begin
        if (I_FRAME_START) begin
          next_state = IMDC_ACTIVE;
          next_flag  = flag_decode(mir[`IMDC_FLAG_MSB:`IMDC_FLAG_LSB]);
          next_width = 6'({1'b0, mir[`IMDC_WIDTH_MSB:0]} + 6'h01);
        end
      end
      IMDC_ACTIVE: begin
        if (I_FRAME_DONE) begin
          next_state = IMDC_IDLE;
        end
      end
      default: next_state = IMDC_IDLE;
    endcase
    next_active = (next_state == IMDC_ACTIVE);
  end

  // pulse timer: counts clocks of this block's clock as the reference clock
  // a pulse already running finishes even when its frame ends
  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (I_PULSE_REQ && state == IMDC_ACTIVE && pulse_cnt == 6'h00) begin
      next_pulse_cnt = O_PULSE_CLKS;
    end else if (pulse_cnt != 6'h00) begin
      next_pulse_cnt = 6'(pulse_cnt - 6'h01);
    end
    next_pulse = (next_pulse_cnt != 6'h00);
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state          <= IMDC_IDLE;
      O_FLAG_COUNT   <= 6'h02;
      O_PULSE_CLKS   <= 6'h0A;
      O_FRAME_ACTIVE <= 1'h0;
      pulse_cnt      <= 6'h00;
      O_IR_PULSE     <= 1'h0;
    end else begin
      state          <= next_state;
      O_FLAG_COUNT   <= next_flag;
      O_PULSE_CLKS   <= next_width;
      O_FRAME_ACTIVE <= next_active;
      pulse_cnt      <= next_pulse_cnt;
      O_IR_PULSE     <= next_pulse;
    end
  end

  // helper: length of the pulse now high, read by the pulse length check
  logic [5:0] hi_len;
  logic [5:0] next_hi_len;

  always_comb begin
    next_hi_len = O_IR_PULSE ? 6'(hi_len + 6'h01) : 6'h00;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      hi_len <= 6'h00;
    end else begin
      hi_len <= next_hi_len;
    end
  end

  // checks below watch only what this block drives
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_mir_write;
    I_WR && hit_mir;
  endsequence

  sequence s_mir_read;
    I_RD && hit_mir && !I_WR;
  endsequence

  sequence s_dma_write;
    I_WR && hit_dma;
  endsequence

  a_mir_readback: assert property (s_mir_write ##1 s_mir_read |=> O_RDATA == {8'h00, $past(I_WDATA[7:0], 2)})
    else $error("mir register read back differs from the value written");

  a_upper_zero: assert property (O_RDATA[15:8] == 8'h00)
    else $error("upper byte of read data is not zero");

  a_dma_rsvd_zero: assert property ((I_RD && hit_dma) |=> O_RDATA[7] == 1'b0 && O_RDATA[5:3] == 3'h0)
    else $error("access mode or reserved dma bits read as one");

  sequence s_dma_read;
    I_RD && hit_dma && !I_WR;
  endsequence

  sequence s_frame_start;
    state == IMDC_IDLE && I_FRAME_START;
  endsequence

  // the expected counts are spelled out here rather than taken from the decoder
  a_flag_decode: assert property (s_frame_start |=> O_FRAME_ACTIVE && O_FLAG_COUNT ==
      (($past(mir[7:5]) == 3'h1) ? 6'h01 :
       ($past(mir[7:5]) == 3'h3) ? 6'h04 :
       ($past(mir[7:5]) == 3'h4) ? 6'h10 :
       ($past(mir[7:5]) == 3'h7) ? 6'h20 : 6'h02))
    else $error("opening flag count not decoded at frame start");

  a_frame_hold: assert property ((state == IMDC_ACTIVE && !I_FRAME_DONE) |=>
      $stable(O_FLAG_COUNT) && $stable(O_PULSE_CLKS))
    else $error("frame settings changed inside a frame");

  a_idle_hold: assert property ((state == IMDC_IDLE && !I_FRAME_START) |=>
      $stable(O_FLAG_COUNT) && $stable(O_PULSE_CLKS))
    else $error("frame settings changed outside a frame start");

  a_frame_end: assert property ((state == IMDC_ACTIVE && I_FRAME_DONE) |=> !O_FRAME_ACTIVE)
    else $error("frame still active after frame done");

  a_idle_stays: assert property ((state == IMDC_IDLE && !I_FRAME_START) |=> !O_FRAME_ACTIVE)
    else $error("frame became active without a frame start");

  a_active_mirror: assert property (O_FRAME_ACTIVE == (state == IMDC_ACTIVE))
    else $error("frame active output disagrees with frame state");

  a_width_decode: assert property (s_frame_start |=> O_PULSE_CLKS == 6'({1'b0, $past(mir[4:0])} + 6'h01))
    else $error("pulse clock count is not width plus one at frame start");

  a_width_range: assert property (O_PULSE_CLKS >= 6'h01 && O_PULSE_CLKS <= 6'h20)
    else $error("pulse clock count outside one to thirty two");

  a_pulse_start: assert property ((state == IMDC_ACTIVE && I_PULSE_REQ && pulse_cnt == 6'h00) |=> O_IR_PULSE)
    else $error("pulse did not start after request");

  a_pulse_count: assert property (pulse_cnt != 6'h00 |=> pulse_cnt == 6'($past(pulse_cnt) - 6'h01))
    else $error("pulse timer did not count down by one");

  a_pulse_mirror: assert property (O_IR_PULSE == (pulse_cnt != 6'h00))
    else $error("pulse output disagrees with pulse timer");

  // a request outside a frame must leave the pin low
  a_pulse_refused: assert property ((!O_FRAME_ACTIVE && !O_IR_PULSE) |=> !O_IR_PULSE)
    else $error("pulse started outside a frame");

  a_pulse_len: assert property ($fell(O_IR_PULSE) |-> hi_len == O_PULSE_CLKS)
    else $error("pulse length differs from width plus one");

  a_rdata_idle: assert property (!I_RD |=> O_RDATA == 16'h0000)
    else $error("read data present without a read");

  a_unmapped_read: assert property ((I_RD && !hit_mir && !hit_dma) |=> O_RDATA == 16'h0000)
    else $error("unmapped read returned nonzero data");

  a_dir_path: assert property (s_dma_write |=> O_TO_TX == !$past(I_WDATA[6]) && O_FROM_RX == $past(I_WDATA[6]))
    else $error("dma direction outputs wrong after write");

  a_dir_onehot: assert property (O_TO_TX != O_FROM_RX)
    else $error("both or neither dma direction selected");

  a_dma_readback: assert property (s_dma_read |=> O_RDATA[6] == O_FROM_RX &&
      O_DEMAND_FREE == (O_RDATA[2:0] == 3'h7))
    else $error("dma read back disagrees with dma steering outputs");

  a_dma_hold: assert property (!(I_WR && hit_dma) |=>
      $stable(O_TO_TX) && $stable(O_FROM_RX) && $stable(O_DEMAND_SIZE) && $stable(O_DEMAND_FREE))
    else $error("dma steering changed without a dma write");

  a_demand_size: assert property (s_dma_write |=> O_DEMAND_FREE == ($past(I_WDATA[2:0]) == 3'h7) &&
      (O_DEMAND_FREE || O_DEMAND_SIZE == 3'($past(I_WDATA[2:0]) + 3'h1)))
    else $error("dma demand size decoded wrongly");

  a_free_size: assert property (O_DEMAND_FREE == (O_DEMAND_SIZE == 3'h0))
    else $error("free size and demand size disagree");

endmodule

// file: dv/imdc_regs_tb.sv
// self-checking bench for the mir/dma configuration bank
`timescale 1ns/1ps
`include "imdc_consts.svh"
module imdc_regs_tb;
  import imdc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0;
  logic        wr = 1'b0, rd = 1'b0, fs = 1'b0, fd = 1'b0, pr = 1'b0;
  logic [15:0] rdata;
  logic [5:0]  flag, clks;
  logic        act, pulse, to_tx, from_rx, free;
  logic [2:0]  dsize;
  int          error_cnt = 0;
  int          total_checks = 0;
  // rows: mir write value, expected flag count, expected pulse clocks
  logic [15:0] mir_wd [8] = '{16'h0000, 16'h003F, 16'h0049, 16'h0074, 16'h0081, 16'h00A2, 16'h00C3, 16'hFFFF};
  logic [5:0]  mir_fl [8] = '{6'h02, 6'h01, 6'h02, 6'h04, 6'h10, 6'h02, 6'h02, 6'h20};
  logic [5:0]  mir_pc [8] = '{6'h01, 6'h20, 6'h0A, 6'h15, 6'h02, 6'h03, 6'h04, 6'h20};

  always #2 clk = ~clk;

  imdc_regs uut (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_FRAME_START(fs), .I_FRAME_DONE(fd), .I_PULSE_REQ(pr), .O_RDATA(rdata), .O_FLAG_COUNT(flag),
    .O_PULSE_CLKS(clks), .O_FRAME_ACTIVE(act), .O_IR_PULSE(pulse), .O_TO_TX(to_tx), .O_FROM_RX(from_rx),
    .O_DEMAND_SIZE(dsize), .O_DEMAND_FREE(free));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands one cycle only, so the idle cycle after it is checked too
  task automatic rd_reg(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
  endtask

  // write then read with no gap, as the bus allows
  task automatic wr_rd(input logic [31:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // start a frame, optionally rewrite mir mid-frame, time one pulse, end the frame
  task automatic frame(input logic [5:0] fl, input logic [5:0] pc, input logic [15:0] mid);
    int n;
    @(posedge clk);
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    #1;
    chk(16'(act), 16'h0001);
    chk(16'(flag), 16'(fl));
    chk(16'(clks), 16'(pc));
    if (mid !== 16'h0000) begin
      wr_reg(`IMDC_MIR_OFS, mid);
      #1;
      chk(16'({flag, clks}), 16'({fl, pc}));
    end
    @(posedge clk);
    pr <= 1'b1;
    @(posedge clk);
    pr <= 1'b0;
    #1;
    n = 0;
    while (pulse === 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(16'(n), 16'(pc));
    @(posedge clk);
    fd <= 1'b1;
    @(posedge clk);
    fd <= 1'b0;
    #1;
    chk(16'(act), 16'h0000);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    logic [2:0] c;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(16'({act, pulse, to_tx, from_rx, free, dsize, clks}), 16'({5'h04, 3'h1, 6'h0A}));
    chk(16'(flag), 16'h0002);
    rd_reg(`IMDC_MIR_OFS, 16'h0049);
    rd_reg(`IMDC_DMA_OFS, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr_reg(`IMDC_MIR_OFS, mir_wd[i]);
      rd_reg(`IMDC_MIR_OFS, mir_wd[i] & 16'h00FF);
      frame(mir_fl[i], mir_pc[i], 16'h0000);
    end
    // reserved and access-mode bits are set on purpose to prove they read back zero
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr_reg(`IMDC_DMA_OFS, {8'hFF, 1'b1, c[0], 3'h7, c});
      rd_reg(`IMDC_DMA_OFS, {8'h00, 1'b0, c[0], 3'h0, c});
      chk(16'({to_tx, from_rx}), 16'({~c[0], c[0]}));
      chk(16'({free, dsize}), 16'({c == 3'h7, (c == 3'h7) ? 3'h0 : c + 3'h1}));
    end
    wr_reg(32'h0C00_0064, 16'hFFFF);
    rd_reg(32'h0C00_0064, 16'h0000);
    rd_reg(`IMDC_DMA_OFS, 16'h0047);
    wr_rd(`IMDC_MIR_OFS, 16'h0054, 16'h0054);
    frame(6'h02, 6'h15, 16'h0000);
    wr_rd(`IMDC_DMA_OFS, 16'h0047, 16'h0047);
    chk(16'({to_tx, from_rx, free, dsize}), 16'({2'b01, 1'b1, 3'h0}));
    wr_reg(`IMDC_MIR_OFS, 16'h0049);
    frame(6'h02, 6'h0A, 16'h0081);
    rd_reg(`IMDC_MIR_OFS, 16'h0081);
    frame(6'h10, 6'h02, 16'h0000);
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    chk(16'({flag, clks}), 16'({6'h02, 6'h0A}));
    chk(16'({to_tx, from_rx, free, dsize}), 16'({2'b10, 1'b0, 3'h1}));
    @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(`IMDC_MIR_OFS, 16'h0049);
    rd_reg(`IMDC_DMA_OFS, 16'h0000);
    wrap_up();
  end
endmodule
